// *** bench/svi_core_model.sv ***
// core model: instruction-end ticks and a fixed-length service routine
// assumes it shares mclk and rst_b with the unit; firmware writes come from the bench
module svi_core_model
  import svi_pkg::*;
#(
  parameter int INSTR_LEN  = 3,
  parameter int SVC_INSTRS = 8
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // unit side
  input  wire logic run,
  input  wire logic call_inject,
  output logic      instr_end,
  output logic      ret_exec
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int left;
  // a stalled core gives no instruction ends, so entry waits with it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt       <= 0;
      instr_end <= 1'b0;
    end else begin
      cnt       <= (run && cnt < INSTR_LEN - 1) ? cnt + 1 : 0;
      instr_end <= run && cnt == INSTR_LEN - 1;
    end
  end
  // return comes a cycle after the last routine instruction, never beside an end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      left     <= 0;
      ret_exec <= 1'b0;
    end else begin
      ret_exec <= instr_end && left == 1;
      if (call_inject) begin
        left <= SVC_INSTRS;
      end else if (instr_end && left != 0) begin
        left <= left - 1;
      end
    end
  end
endmodule : svi_core_model

// *** bench/svi_unit_bench.sv ***
// self-checking bench for the single-vector interrupt unit
// assumes the core model paces instructions; events and registers are driven here
module svi_unit_bench;
  import svi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [9:0]  evt = 10'h000;
  logic        pin_wake_armed = 1'b0;
  logic        core_run = 1'b0;
  logic [7:0]  reg_rdata;
  logic [11:0] call_addr;
  logic        instr_end, ret_exec, call_inject, in_service, irq_req;
  logic        wake_timer_run, wake_up, touch_module_start, prev_ie;
  int          num_errors = 0;
  int          checks_done = 0;
  int          n_calls = 0;
  // flag bits per event: conv, long, second, first, wake, low, tmod, scan, serial, pin
  logic [7:0]  ev_bits [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08,
                                8'h80, 8'h18, 8'h08, 8'h02, 8'h01};
  svi_unit svi_unit_i (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_done_evt(evt[0]), .long_timer_evt(evt[1]), .second_timer_evt(evt[2]),
    .first_timer_evt(evt[3]), .wake_timer_evt(evt[4]), .low_supply_evt(evt[5]),
    .touch_module_evt(evt[6]), .touch_auto_scan_evt(evt[7]), .serial_port_evt(evt[8]),
    .pin_change_evt(evt[9]), .pin_wake_armed, .instr_end, .ret_exec, .call_inject,
    .call_addr, .in_service, .irq_req, .wake_timer_run, .wake_up, .touch_module_start);
  svi_core_model svi_core_model_i (.mclk, .rst_b, .run(core_run), .call_inject, .instr_end,
    .ret_exec);
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    if (call_inject === 1'b1) begin
      n_calls++;
      chk_bit("entry_after_end", prev_ie, 1'b1);
    end
    prev_ie <= instr_end;
  end
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic chk_bit(input string name, input logic seen, input logic exp);
    chk(name, {11'h000, seen}, {11'h000, exp});
  endtask : chk_bit
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(name, {4'h0, reg_rdata}, {4'h0, exp});
  endtask : rd_chk
  task automatic pulse(input int i);
    @(posedge mclk);
    evt[i] <= 1'b1;
    @(posedge mclk);
    evt[i] <= 1'b0;
  endtask : pulse
  // bounded wait for a service call or for the in-service flag to drop
  task automatic wait_until(input bit want_call);
    for (int k = 0; k < 80; k++) begin
      @(posedge mclk);
      #1;
      if (want_call ? call_inject === 1'b1 : in_service === 1'b0) return;
    end
    num_errors++;
    tally_and_finish();
  endtask : wait_until
  task automatic regs_scn();
    rd_chk("en_pri_rst", ADDR_IRQ_ENABLE_PRIMARY, RESET_BYTE);
    rd_chk("fl_pri_rst", ADDR_IRQ_FLAGS_PRIMARY, RESET_BYTE);
    rd_chk("en_sec_rst", ADDR_IRQ_ENABLE_SECONDARY, RESET_BYTE);
    rd_chk("fl_sec_rst", ADDR_IRQ_FLAGS_SECONDARY, RESET_BYTE);
    wr(8'h20, 8'hff);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(ADDR_IRQ_ENABLE_PRIMARY, 8'hff);
    rd_chk("en_pri", ADDR_IRQ_ENABLE_PRIMARY, 8'hf8);
    chk_bit("wake_run_on", wake_timer_run, 1'b1);
    wr(ADDR_IRQ_ENABLE_PRIMARY, 8'h00);
    #1;
    chk_bit("wake_run_off", wake_timer_run, 1'b0);
    wr(ADDR_IRQ_ENABLE_SECONDARY, 8'hff);
    rd_chk("en_sec", ADDR_IRQ_ENABLE_SECONDARY, MASK_SECONDARY);
    wr(ADDR_IRQ_ENABLE_SECONDARY, 8'h00);
  endtask : regs_scn
  task automatic flags_scn();
    logic [7:0] fa;
    logic [7:0] ea;
    for (int i = 0; i < 10; i++) begin
      fa = (i < 5) ? ADDR_IRQ_FLAGS_PRIMARY : ADDR_IRQ_FLAGS_SECONDARY;
      ea = (i < 5) ? ADDR_IRQ_ENABLE_PRIMARY : ADDR_IRQ_ENABLE_SECONDARY;
      pulse(i);
      #1;
      chk_bit("irq_disabled", irq_req, 1'b0);
      rd_chk("flag_set", fa, ev_bits[i]);
      wr(fa, 8'hff);
      rd_chk("flag_kept", fa, ev_bits[i]);
      wr(ea, (i < 5) ? ev_bits[i] : ev_bits[i] & 8'h8b);
      #1;
      chk_bit("irq_enabled", irq_req, 1'b1);
      wr(ea, 8'h00);
      wr(fa, ~ev_bits[i]);
      rd_chk("flag_clr", fa, 8'h00);
    end
  endtask : flags_scn
  task automatic touch_scn();
    pulse(6);
    wr(ADDR_IRQ_FLAGS_SECONDARY, 8'hef);
    rd_chk("touch_mod_clr", ADDR_IRQ_FLAGS_SECONDARY, 8'h08);
    pulse(6);
    wr(ADDR_TOUCH_CTRL, 8'h01);
    #1;
    chk_bit("touch_start", touch_module_start, 1'b1);
    rd_chk("touch_start_clr", ADDR_IRQ_FLAGS_SECONDARY, 8'h00);
    pulse(6);
    wr(ADDR_IRQ_FLAGS_SECONDARY, 8'hf7);
    rd_chk("touch_flag_clr", ADDR_IRQ_FLAGS_SECONDARY, 8'h00);
  endtask : touch_scn
  task automatic entry_scn();
    int c0;
    int n;
    @(posedge mclk);
    core_run <= 1'b1;
    wr(ADDR_IRQ_ENABLE_PRIMARY, 8'h10);
    pulse(3);
    wait_until(1'b1);
    chk("vector", call_addr, SERVICE_VECTOR);
    chk_bit("in_service", in_service, 1'b1);
    chk_bit("no_nest_req", irq_req, 1'b0);
    rd_chk("flag_on_entry", ADDR_IRQ_FLAGS_PRIMARY, 8'h10);
    // the monitor counts a call on the edge that ends it, so take the count after that edge
    c0 = n_calls;
    wr(ADDR_IRQ_FLAGS_PRIMARY, 8'hef);
    pulse(3);
    wait_until(1'b0);
    chk("no_nesting", 12'(n_calls), 12'(c0));
    n = 0;
    for (int k = 0; k < 40 && call_inject !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
      if (instr_end === 1'b1) n++;
    end
    chk_bit("reentry", call_inject, 1'b1);
    chk_bit("main_instr_gap", n >= 1, 1'b1);
    wr(ADDR_IRQ_ENABLE_PRIMARY, 8'h00);
    wr(ADDR_IRQ_FLAGS_PRIMARY, 8'h00);
    wait_until(1'b0);
  endtask : entry_scn
  task automatic wake_scn();
    int  c0;
    logic w;
    c0 = n_calls;
    @(posedge mclk);
    pin_wake_armed <= 1'b1;
    pulse(9);
    #1;
    w = wake_up;
    @(posedge mclk);
    #1;
    w = w | wake_up;
    chk_bit("wake_up", w, 1'b1);
    rd_chk("pin_flag", ADDR_IRQ_FLAGS_SECONDARY, 8'h01);
    repeat (12) @(posedge mclk);
    chk("no_service", 12'(n_calls), 12'(c0));
  endtask : wake_scn
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    regs_scn();
    flags_scn();
    touch_scn();
    entry_scn();
    wake_scn();
    tally_and_finish();
  end
endmodule : svi_unit_bench

// *** src/svi_entry_ctrl.sv ***
// entry and return sequencing for the single service vector
// assumes core gives instruction-end and return strobes
module svi_entry_ctrl
  import svi_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // core
  input  wire logic        req,
  input  wire logic        instr_end,
  input  wire logic        ret_exec,
  output logic             call_inject,
  output logic      [11:0] call_addr,
  output logic             in_service
);
  svi_state_t state;
  svi_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      SVI_IDLE:     if (req && instr_end) next_state = SVI_BUSY; // RULE_03
      SVI_BUSY:     if (ret_exec) next_state = SVI_RET_PEND;
      // one more instruction runs before entry can reopen
      SVI_RET_PEND: if (instr_end) next_state = SVI_IDLE; // RULE_05
      default:      next_state = SVI_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SVI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      call_inject <= 1'b0;
      call_addr   <= 12'h000;
    end else begin
      call_inject <= (state == SVI_IDLE) && req && instr_end; // RULE_04
      call_addr   <= SERVICE_VECTOR;
    end
  end

  assign in_service = (state != SVI_IDLE); // RULE_04

  a_entry_blocked: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_04
    call_inject |-> ##1 !call_inject [*2])
    else $error("back to back vector calls");
  a_entry_at_end: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_03
    call_inject |-> $past(instr_end) && $past(req))
    else $error("entry not at instruction end");
  a_return_gap: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_05
    (state == SVI_BUSY && ret_exec) |=> in_service)
    else $error("in-service dropped at return");
endmodule : svi_entry_ctrl

// *** src/svi_flag_bank.sv ***
// sticky flag byte: hardware set, software write-0 clear
// assumes set pulses and write strobes are synchronous to mclk
module svi_flag_bank
  import svi_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // control
  input  wire logic [7:0] set_evt,
  input  wire logic [7:0] clr,
  // state
  output logic      [7:0] flags
);
  // set wins over clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= RESET_BYTE;
    end else begin
      flags <= ((flags & ~clr) | set_evt) & MASK;
    end
  end
endmodule : svi_flag_bank

// *** src/svi_pkg.sv ***
// constants for the single-vector interrupt unit
// assumes one 10 MHz clock and a plain strobe register port
package svi_pkg;
  localparam logic [7:0] ADDR_IRQ_ENABLE_PRIMARY   = 8'h0b;
  localparam logic [7:0] ADDR_IRQ_FLAGS_PRIMARY    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ENABLE_SECONDARY = 8'h0e;
  localparam logic [7:0] ADDR_IRQ_FLAGS_SECONDARY  = 8'h1a;
  localparam logic [7:0] ADDR_TOUCH_CTRL           = 8'h1b;
  localparam logic [7:0] RESET_BYTE                = 8'h00;
  // implemented bits of each register
  localparam logic [7:0] MASK_PRIMARY   = 8'hf8;
  localparam logic [7:0] MASK_SECONDARY = 8'h9b;
  // primary register bit positions
  localparam int BIT_CONV_DONE   = 7;
  localparam int BIT_LONG_TIMER  = 6;
  localparam int BIT_SECOND_TMR  = 5;
  localparam int BIT_FIRST_TMR   = 4;
  localparam int BIT_WAKE_TIMER  = 3;
  // secondary register bit positions
  localparam int BIT_LOW_SUPPLY  = 7;
  localparam int BIT_TOUCH_MOD   = 4;
  localparam int BIT_TOUCH       = 3;
  localparam int BIT_SERIAL_PORT = 1;
  localparam int BIT_PIN_CHANGE  = 0;
  // touch control register: start-conversion bit
  localparam int BIT_TOUCH_START = 0;
  localparam logic [11:0] SERVICE_VECTOR = 12'h004;
  typedef enum logic [1:0] {SVI_IDLE, SVI_BUSY, SVI_RET_PEND} svi_state_t;
endpackage : svi_pkg

// *** src/svi_unit.sv ***
// single-level, single-vector interrupt unit
// assumes event inputs are one-cycle pulses on mclk, and a plain register port
// Summary of operation
// RULE_01: one level, one vector, nine sources, each with its own enable
// RULE_02: events set flags regardless of their enable bit
// RULE_03: interrupt taken only at end of current instruction
// RULE_04: acceptance injects call to 004 and sets in-service, blocking nesting
// RULE_05: in-service clears one instruction after return-from-irq
// RULE_06: firmware clears the flag itself; hardware never clears on entry
// RULE_07: primary enables bits 7..3: conv, long, second, first, wake timer
// RULE_08: wake timer enable also runs the wake timer
// RULE_09: primary flag bit 7 set on conversion done, cleared by writing 0
// RULE_10: primary flag bits 6,5,4 set on timer overflows, write 0 clears
// RULE_11: secondary enables: low supply 7, touch 3, serial 1, pin change 0; the code also keeps enable bit 4 (touch module) writable
// RULE_12: secondary flag bit 7 set on low supply, write 0 clears
// RULE_13: touch module flag cleared by own 0, touch flag 0, or start
// RULE_14: touch flag set on scan/module done; 0 or start clears both
// RULE_15: secondary flag bit 1 set on serial transfer done, write 0 clears
// RULE_16: secondary flag bit 0 set on pin change, write 0 clears
// RULE_17: primary flag bit 3 set on wake timer timeout, write 0 clears
// RULE_18: wake pin change sets flag and wakes even when not enabled
// RULE_19: request while any enabled flag set and not in service
// RULE_20: writing 1 to a flag leaves it unchanged
//
// Added by the designer: the address-and-strobe port.
module svi_unit
  import svi_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // peripheral events
  input  wire logic        conv_done_evt,
  input  wire logic        long_timer_evt,
  input  wire logic        second_timer_evt,
  input  wire logic        first_timer_evt,
  input  wire logic        wake_timer_evt,
  input  wire logic        low_supply_evt,
  input  wire logic        touch_module_evt,
  input  wire logic        touch_auto_scan_evt,
  input  wire logic        serial_port_evt,
  input  wire logic        pin_change_evt,
  input  wire logic        pin_wake_armed,
  // core
  input  wire logic        instr_end,
  input  wire logic        ret_exec,
  output logic             call_inject,
  output logic      [11:0] call_addr,
  output logic             in_service,
  output logic             irq_req,
  // power and peripherals
  output logic             wake_timer_run,
  output logic             wake_up,
  output logic             touch_module_start
);
  logic [7:0] irq_enable_primary;
  logic [7:0] irq_enable_secondary;
  logic [7:0] irq_flags_primary;
  logic [7:0] irq_flags_secondary;
  logic [7:0] set_primary;
  logic [7:0] set_secondary;
  logic [7:0] clr_primary;
  logic [7:0] clr_secondary;
  logic       touch_start_wr;
  logic       touch_clr_all;
  logic       any_pending;

  // write hits one address; a 0 in a flag byte clears, a 1 keeps
  function automatic logic [7:0] zero_clear(input logic hit, input logic [7:0] d);
    zero_clear = hit ? ~d : 8'h00; // RULE_20
  endfunction : zero_clear

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_enable_primary   <= RESET_BYTE;
      irq_enable_secondary <= RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_IRQ_ENABLE_PRIMARY)
        irq_enable_primary <= reg_wdata & MASK_PRIMARY; // RULE_07
      if (reg_addr == ADDR_IRQ_ENABLE_SECONDARY)
        irq_enable_secondary <= reg_wdata & MASK_SECONDARY; // RULE_11
    end
  end

  // start bit is self-clearing: a one-cycle strobe to the touch module
  assign touch_start_wr = reg_wr && (reg_addr == ADDR_TOUCH_CTRL)
                          && reg_wdata[BIT_TOUCH_START];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      touch_module_start <= 1'b0;
    end else begin
      touch_module_start <= touch_start_wr;
    end
  end

  // sets ignore the enables so disabled sources can be polled
  always_comb begin
    set_primary                  = 8'h00; // RULE_02
    set_primary[BIT_CONV_DONE]   = conv_done_evt; // RULE_09
    set_primary[BIT_LONG_TIMER]  = long_timer_evt; // RULE_10
    set_primary[BIT_SECOND_TMR]  = second_timer_evt;
    set_primary[BIT_FIRST_TMR]   = first_timer_evt;
    set_primary[BIT_WAKE_TIMER]  = wake_timer_evt; // RULE_17
    set_secondary                  = 8'h00;
    set_secondary[BIT_LOW_SUPPLY]  = low_supply_evt; // RULE_12
    set_secondary[BIT_TOUCH_MOD]   = touch_module_evt; // RULE_13
    set_secondary[BIT_TOUCH]       = touch_module_evt | touch_auto_scan_evt; // RULE_14
    set_secondary[BIT_SERIAL_PORT] = serial_port_evt; // RULE_15
    set_secondary[BIT_PIN_CHANGE]  = pin_change_evt; // RULE_16
  end

  assign touch_clr_all = (reg_wr && reg_addr == ADDR_IRQ_FLAGS_SECONDARY
                          && !reg_wdata[BIT_TOUCH]) || touch_start_wr;

  // no clear source from entry or return: only software writes clear
  always_comb begin
    clr_primary   = zero_clear(reg_wr && reg_addr == ADDR_IRQ_FLAGS_PRIMARY,
                               reg_wdata); // RULE_06
    clr_secondary = zero_clear(reg_wr && reg_addr == ADDR_IRQ_FLAGS_SECONDARY,
                               reg_wdata);
    if (touch_clr_all) begin
      clr_secondary[BIT_TOUCH_MOD] = 1'b1; // RULE_13
      clr_secondary[BIT_TOUCH]     = 1'b1; // RULE_14
    end
  end

  svi_flag_bank #(.MASK(MASK_PRIMARY)) u_flags_primary (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .set_evt (set_primary),
    .clr     (clr_primary),
    .flags   (irq_flags_primary)
  );

  svi_flag_bank #(.MASK(MASK_SECONDARY)) u_flags_secondary (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .set_evt (set_secondary),
    .clr     (clr_secondary),
    .flags   (irq_flags_secondary)
  );

  assign any_pending = |(irq_flags_primary & irq_enable_primary)
                     | |(irq_flags_secondary & irq_enable_secondary); // RULE_01
  assign irq_req = any_pending && !in_service; // RULE_19

  svi_entry_ctrl u_entry (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .req         (irq_req),
    .instr_end   (instr_end),
    .ret_exec    (ret_exec),
    .call_inject (call_inject),
    .call_addr   (call_addr),
    .in_service  (in_service)
  );

  assign wake_timer_run = irq_enable_primary[BIT_WAKE_TIMER]; // RULE_08
  // armed pin change wakes the core even with its enable off
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= (pin_change_evt && pin_wake_armed) || any_pending; // RULE_18
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_IRQ_ENABLE_PRIMARY:   reg_rdata <= irq_enable_primary;
        ADDR_IRQ_FLAGS_PRIMARY:    reg_rdata <= irq_flags_primary;
        ADDR_IRQ_ENABLE_SECONDARY: reg_rdata <= irq_enable_secondary;
        ADDR_IRQ_FLAGS_SECONDARY:  reg_rdata <= irq_flags_secondary;
        default:                   reg_rdata <= RESET_BYTE;
      endcase
    end else begin
      reg_rdata <= RESET_BYTE;
    end
  end

  a_flag_set_event: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_02
    conv_done_evt |=> irq_flags_primary[BIT_CONV_DONE])
    else $error("conversion flag not set");
  a_write_one_keeps: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_20
    (reg_wr && reg_addr == ADDR_IRQ_FLAGS_PRIMARY && reg_wdata[BIT_FIRST_TMR]
     && irq_flags_primary[BIT_FIRST_TMR]) |=> irq_flags_primary[BIT_FIRST_TMR])
    else $error("write one cleared flag");
  a_zero_clears: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_15
    (reg_wr && reg_addr == ADDR_IRQ_FLAGS_SECONDARY && !reg_wdata[BIT_SERIAL_PORT]
     && !serial_port_evt) |=> !irq_flags_secondary[BIT_SERIAL_PORT])
    else $error("serial flag not cleared");
  a_touch_start_clr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_14
    (touch_start_wr && !touch_module_evt && !touch_auto_scan_evt)
      |=> !irq_flags_secondary[BIT_TOUCH] && !irq_flags_secondary[BIT_TOUCH_MOD])
    else $error("touch flags survive start");
  a_req_gated: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_19
    irq_req |-> !in_service)
    else $error("request during service");
  // a write seen on the previous edge is what changed the flags at this one
  a_no_hw_clear: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_06
    (call_inject && !$past(reg_wr)) |-> $stable(irq_flags_primary)
      || ($past(irq_flags_primary) & ~irq_flags_primary) == 8'h00)
    else $error("flag cleared by entry");

  // each event sets its own flag whatever the enables hold
  a_long_timer_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_10
    long_timer_evt |=> irq_flags_primary[BIT_LONG_TIMER])
    else $error("long timer flag not set");
  a_second_tmr_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_10
    second_timer_evt |=> irq_flags_primary[BIT_SECOND_TMR])
    else $error("second timer flag not set");
  a_first_tmr_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_10
    first_timer_evt |=> irq_flags_primary[BIT_FIRST_TMR])
    else $error("first timer flag not set");
  a_wake_flag_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_17
    wake_timer_evt |=> irq_flags_primary[BIT_WAKE_TIMER])
    else $error("wake timer flag not set");
  a_low_supply_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_12
    low_supply_evt |=> irq_flags_secondary[BIT_LOW_SUPPLY])
    else $error("low supply flag not set");
  a_touch_mod_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_13
    touch_module_evt |=> irq_flags_secondary[BIT_TOUCH_MOD] && irq_flags_secondary[BIT_TOUCH])
    else $error("touch module flags not set");
  a_scan_sets_touch: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_14
    touch_auto_scan_evt |=> irq_flags_secondary[BIT_TOUCH])
    else $error("scan did not set touch flag");
  a_serial_flag_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_15
    serial_port_evt |=> irq_flags_secondary[BIT_SERIAL_PORT])
    else $error("serial flag not set");
  a_pin_flag_set: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_16
    pin_change_evt |=> irq_flags_secondary[BIT_PIN_CHANGE])
    else $error("pin change flag not set");

  // a 0 clears its flag unless the event lands in the same cycle
  a_conv_zero_clr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_09
    (reg_wr && reg_addr == ADDR_IRQ_FLAGS_PRIMARY && !reg_wdata[BIT_CONV_DONE]
     && !conv_done_evt) |=> !irq_flags_primary[BIT_CONV_DONE])
    else $error("conversion flag not cleared");
  a_long_zero_clr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_10
    (reg_wr && reg_addr == ADDR_IRQ_FLAGS_PRIMARY && !reg_wdata[BIT_LONG_TIMER]
     && !long_timer_evt) |=> !irq_flags_primary[BIT_LONG_TIMER])
    else $error("long timer flag not cleared");
  a_pin_zero_clr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_16
    (reg_wr && reg_addr == ADDR_IRQ_FLAGS_SECONDARY && !reg_wdata[BIT_PIN_CHANGE]
     && !pin_change_evt) |=> !irq_flags_secondary[BIT_PIN_CHANGE])
    else $error("pin change flag not cleared");
  a_touch_zero_clr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_13
    (reg_wr && reg_addr == ADDR_IRQ_FLAGS_SECONDARY && !reg_wdata[BIT_TOUCH]
     && !touch_module_evt) |=> !irq_flags_secondary[BIT_TOUCH_MOD])
    else $error("touch module flag survives");

  // no entry, return or enable write may drop a flag
  a_sticky_primary: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_06
    !(reg_wr && reg_addr == ADDR_IRQ_FLAGS_PRIMARY)
      |=> ($past(irq_flags_primary) & ~irq_flags_primary) == 8'h00)
    else $error("primary flag fell without a write");
  a_sticky_secondary: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_06
    !(reg_wr && (reg_addr == ADDR_IRQ_FLAGS_SECONDARY || reg_addr == ADDR_TOUCH_CTRL))
      |=> ($past(irq_flags_secondary) & ~irq_flags_secondary) == 8'h00)
    else $error("secondary flag fell without a write");

  // enable bytes follow writes, unimplemented bits stay 0
  a_enable_pri_wr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_07
    (reg_wr && reg_addr == ADDR_IRQ_ENABLE_PRIMARY)
      |=> irq_enable_primary == ($past(reg_wdata) & MASK_PRIMARY))
    else $error("primary enable write lost");
  a_enable_sec_wr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_11
    (reg_wr && reg_addr == ADDR_IRQ_ENABLE_SECONDARY)
      |=> irq_enable_secondary == ($past(reg_wdata) & MASK_SECONDARY))
    else $error("secondary enable write lost");
  a_wake_run_wr: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_08
    (reg_wr && reg_addr == ADDR_IRQ_ENABLE_PRIMARY)
      |=> wake_timer_run == $past(reg_wdata[BIT_WAKE_TIMER]))
    else $error("wake timer run not following enable");
  a_read_flags_pri: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_09
    (reg_rd && reg_addr == ADDR_IRQ_FLAGS_PRIMARY)
      |=> reg_rdata == $past(irq_flags_primary))
    else $error("primary flags misread");
  a_read_flags_sec: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_12
    (reg_rd && reg_addr == ADDR_IRQ_FLAGS_SECONDARY)
      |=> reg_rdata == $past(irq_flags_secondary))
    else $error("secondary flags misread");

  // request and entry against flags, enables and vector
  a_disabled_quiet: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_19
    (irq_enable_primary == RESET_BYTE && irq_enable_secondary == RESET_BYTE)
      |-> !irq_req)
    else $error("request with all sources disabled");
  a_enabled_request: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_19
    (!in_service && irq_flags_primary[BIT_FIRST_TMR] && irq_enable_primary[BIT_FIRST_TMR])
      |-> irq_req)
    else $error("enabled flag gave no request");
  a_call_vector: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_04
    call_inject |-> call_addr == SERVICE_VECTOR && in_service)
    else $error("call without vector or service");
  a_pin_wake: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_18
    (pin_change_evt && pin_wake_armed) |=> wake_up && irq_flags_secondary[BIT_PIN_CHANGE])
    else $error("armed pin change did not wake");
  a_pin_no_service: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_18
    (irq_enable_secondary == RESET_BYTE && irq_flags_primary == RESET_BYTE
     && irq_flags_secondary[BIT_PIN_CHANGE]) |-> !irq_req)
    else $error("disabled pin change requested service");
  a_start_strobe: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_13
    touch_start_wr |=> touch_module_start)
    else $error("start strobe missing");
endmodule : svi_unit
